// >>> rtl/spir_top.sv
// serial port pin control and infrared pulse codec with an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "spir_cfg.svh"
module spir_top (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              DOZE,
  input  wire logic              BAUD_X16_TICK,
  input  wire logic              SERIAL_TXD,
  output logic                   SERIAL_RXD,
  input  wire logic              SERIAL_TX_ACTIVE,
  input  wire logic              SERIAL_RX_ACTIVE,
  output logic                   SERIAL_ENABLE,
  output logic                   PULLUP_ON,
  input  wire logic              TXD_PIN_IN,
  output logic                   TXD_PIN_OUT,
  output logic                   TXD_PIN_OE_N,
  input  wire logic              RXD_PIN_IN,
  output logic                   RXD_PIN_OUT,
  output logic                   RXD_PIN_OE_N
);
  import spir_pkg::*;

  // ==================================================
  // registers
  spir_byte_t dir_r;
  spir_byte_t port_r;
  spir_byte_t pudz_r;
  spir_byte_t irdiv_r;
  spir_byte_t irctl_r;
  spir_byte_t test_r;
  logic       ir_enable;
  logic       ir_sample_clock_select;
  logic       ir_rx_invert;
  logic       ir_tx_invert;
  logic [1:0] ir_rx_vote_count;
  logic [1:0] ir_tx_pulse_width;
  logic       stop_in_doze;
  logic       active;

  assign ir_enable              = irctl_r[`SPIR_IRC_EN];
  assign ir_sample_clock_select = irctl_r[`SPIR_IRC_SCLK];
  assign ir_rx_invert           = irctl_r[`SPIR_IRC_RX_INV];
  assign ir_tx_invert           = irctl_r[`SPIR_IRC_TX_INV];
  assign ir_rx_vote_count       = irctl_r[`SPIR_IRC_VOTE_LO +: 2];
  assign ir_tx_pulse_width      = irctl_r[`SPIR_IRC_PW_LO +: 2];
  assign stop_in_doze           = pudz_r[`SPIR_PD_DOZE];
  // doze gating of the serial enable and the infrared codec
  assign active                 = !(stop_in_doze && DOZE);
  assign SERIAL_ENABLE          = active;
  // pullups are fixed on; the stored bit is only readable
  assign PULLUP_ON              = 1'b1;

  // ==================================================
  // apb slave, zero wait states
  logic [3:0] idx;
  logic       wr_en;
  logic       hit;
  assign idx     = PADDR[5:2];
  assign hit     = (PADDR[7:6] == 2'b00) && (PADDR[1:0] == 2'b00) &&
                   (idx == `SPIR_IDX_DIR || idx == `SPIR_IDX_PORT || idx == `SPIR_IDX_PUDZ ||
                    idx == `SPIR_IDX_IRDIV || idx == `SPIR_IDX_IRCTL || idx == `SPIR_IDX_TEST);
  assign wr_en   = PSEL && PENABLE && PWRITE && hit;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // register writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dir_r   <= 8'h00;
      port_r  <= 8'h00;
      pudz_r  <= 8'h00;
      irdiv_r <= 8'h00;
      irctl_r <= `SPIR_IRC_RST;
      test_r  <= 8'h00;
    end else if (wr_en) begin
      unique case (idx)
        `SPIR_IDX_DIR:   dir_r   <= PWDATA[7:0];
        `SPIR_IDX_PORT:  port_r  <= PWDATA[7:0];
        `SPIR_IDX_PUDZ:  pudz_r  <= PWDATA[7:0];
        `SPIR_IDX_IRDIV: irdiv_r <= PWDATA[7:0];
        `SPIR_IDX_IRCTL: irctl_r <= PWDATA[7:0];
        default:         test_r  <= PWDATA[7:0];
      endcase
    end
  end

  // pin synchronisers; first stage feeds only the second
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_r <= 2'b11;
      pin_s2_r <= 2'b11;
    end else begin
      pin_s1_r <= {TXD_PIN_IN, RXD_PIN_IN};
      pin_s2_r <= pin_s1_r;
    end
  end

  // port bit read view: pin level when input, latch when output
  spir_pin2_t port_view;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_view
      assign port_view[g] = dir_r[g] ? port_r[g] : pin_s2_r[g];
    end
  endgenerate

  // read mux, data from flip-flops
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= 32'h0000_0000;
      // refused addresses read zero; the word index alone would alias unaligned offsets
      if (hit) begin
        unique case (idx)
          `SPIR_IDX_DIR:   PRDATA[7:0] <= dir_r;
          `SPIR_IDX_PORT:  PRDATA[7:0] <= {port_r[7:2], port_view};
          `SPIR_IDX_PUDZ:  PRDATA[7:0] <= pudz_r;
          `SPIR_IDX_IRDIV: PRDATA[7:0] <= irdiv_r;
          `SPIR_IDX_IRCTL: PRDATA[7:0] <= irctl_r;
          `SPIR_IDX_TEST:  PRDATA[7:0] <= test_r;
          default:         PRDATA[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ==================================================
  // infrared sample tick: divided system clock or baud x16
  logic [7:0] div_cnt_r;
  logic       div_tick;
  logic       samp_tick;
  assign div_tick  = (irdiv_r != 8'h00) && (div_cnt_r == 8'h00);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_cnt_r <= 8'h00;
    end else if (div_cnt_r == 8'h00) begin
      div_cnt_r <= (irdiv_r == 8'h00) ? 8'h00 : irdiv_r - 8'h01;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h01;
    end
  end
  assign samp_tick = ir_sample_clock_select ? div_tick : BAUD_X16_TICK;

  // ==================================================
  // half-duplex direction state
  spir_dir_e dir_st_r;
  logic      tx_zero;
  assign tx_zero = ir_enable && active && !SERIAL_TXD;
  always_ff @(posedge CLK) begin
    if (!RST_N || !ir_enable || !active) begin
      dir_st_r <= SPIR_IDLE;
    end else begin
      unique case (dir_st_r)
        SPIR_IDLE: dir_st_r <= SERIAL_TX_ACTIVE ? SPIR_TXP :
                               (SERIAL_RX_ACTIVE ? SPIR_RXP : SPIR_IDLE);
        SPIR_TXP:  dir_st_r <= SERIAL_TX_ACTIVE ? SPIR_TXP : SPIR_IDLE;
        SPIR_RXP:  dir_st_r <= SERIAL_TX_ACTIVE ? SPIR_TXP :
                               (SERIAL_RX_ACTIVE ? SPIR_RXP : SPIR_IDLE);
        default:   dir_st_r <= SPIR_IDLE;
      endcase
    end
  end

  // encoder: pulse of width code+1 baud ticks (3 for code 3) at start of each zero bit
  logic [3:0] tx_ph_r;
  logic       tx_prev_r;
  logic       tx_pulse_r;
  logic [1:0] pw_eff;
  assign pw_eff = (ir_tx_pulse_width == 2'b11) ? 2'b10 : ir_tx_pulse_width; // reserved -> widest
  always_ff @(posedge CLK) begin
    if (!RST_N || !tx_zero) begin
      tx_ph_r    <= 4'h0;
      tx_pulse_r <= 1'b0;
    end else if (!tx_prev_r || (BAUD_X16_TICK && tx_ph_r == `SPIR_TICKS_PER_BIT)) begin
      tx_ph_r    <= 4'h0;
      tx_pulse_r <= 1'b1;
    end else if (BAUD_X16_TICK) begin
      tx_ph_r    <= tx_ph_r + 4'h1;
      tx_pulse_r <= (tx_ph_r < {2'b00, pw_eff});
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_prev_r <= 1'b0;
    end else begin
      tx_prev_r <= tx_zero;
    end
  end
  // ticks seen while a pulse stands, for the width check below
  logic [2:0] pulse_ticks_r;
  always_ff @(posedge CLK) begin
    if (!RST_N || !tx_pulse_r) begin
      pulse_ticks_r <= 3'h0;
    end else if (BAUD_X16_TICK) begin
      pulse_ticks_r <= pulse_ticks_r + 3'h1;
    end
  end

  // decoder vote: consecutive samples at active level
  logic       rx_act_lvl;
  logic [2:0] vote_r;
  logic       rx_bit_r;
  logic       rx_allowed;
  assign rx_act_lvl = ir_rx_invert ? pin_s2_r[`SPIR_PIN_RX] : !pin_s2_r[`SPIR_PIN_RX];
  assign rx_allowed = ir_enable && active && (dir_st_r != SPIR_TXP);
  always_ff @(posedge CLK) begin
    if (!RST_N || !rx_allowed) begin
      vote_r   <= 3'h0;
      rx_bit_r <= 1'b1;
    end else if (samp_tick) begin
      if (!rx_act_lvl) begin
        vote_r   <= 3'h0;
        rx_bit_r <= 1'b1;
      end else if (vote_r >= {1'b0, ir_rx_vote_count}) begin
        rx_bit_r <= 1'b0;
      end else begin
        vote_r   <= vote_r + 3'h1;
      end
    end
  end

  // ==================================================
  // pin muxing: ir codec, serial, or general-purpose port
  always_comb begin
    if (ir_enable) begin
      TXD_PIN_OUT  = tx_pulse_r ^ ir_tx_invert;
      TXD_PIN_OE_N = 1'b0;
      RXD_PIN_OUT  = 1'b0;
      RXD_PIN_OE_N = 1'b1;
      SERIAL_RXD   = rx_bit_r;
    end else begin
      TXD_PIN_OUT  = SERIAL_TX_ACTIVE ? SERIAL_TXD : port_r[`SPIR_PIN_TX];
      TXD_PIN_OE_N = !(SERIAL_TX_ACTIVE || dir_r[`SPIR_PIN_TX]);
      RXD_PIN_OUT  = port_r[`SPIR_PIN_RX];
      // receive pin serving the serial input is never driven
      RXD_PIN_OE_N = SERIAL_RX_ACTIVE || !dir_r[`SPIR_PIN_RX];
      SERIAL_RXD   = pin_s2_r[`SPIR_PIN_RX];
    end
  end

  // ==================================================
  // checks
  property p_port_read;
    @(posedge CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && idx == `SPIR_IDX_PORT) |=> (PRDATA[7:2] == $past(port_r[7:2]));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read reserved mismatch");

  property p_rx_no_drive;
    @(posedge CLK) disable iff (!RST_N)
      (!ir_enable && SERIAL_RX_ACTIVE) |-> RXD_PIN_OE_N;
  endproperty
  a_rx_no_drive: assert property (p_rx_no_drive) else $error("serial input pin driven");

  property p_in_no_drive;
    @(posedge CLK) disable iff (!RST_N)
      (!ir_enable && !dir_r[`SPIR_PIN_RX]) |-> RXD_PIN_OE_N;
  endproperty
  a_in_no_drive: assert property (p_in_no_drive) else $error("input pin driven");

  property p_doze;
    @(posedge CLK) disable iff (!RST_N)
      (stop_in_doze && DOZE) |-> !SERIAL_ENABLE;
  endproperty
  a_doze: assert property (p_doze) else $error("interface active in doze");

  property p_ir_rx_idle;
    @(posedge CLK) disable iff (!RST_N)
      (ir_enable && dir_st_r == SPIR_TXP) |=> SERIAL_RXD;
  endproperty
  a_ir_rx_idle: assert property (p_ir_rx_idle) else $error("receive during transmit");

  property p_ir_one;
    @(posedge CLK) disable iff (!RST_N)
      (ir_enable && samp_tick && !rx_act_lvl) |=> SERIAL_RXD;
  endproperty
  a_ir_one: assert property (p_ir_one) else $error("one not reported on idle line");

  property p_tx_idle_lvl;
    @(posedge CLK) disable iff (!RST_N)
      (ir_enable && !tx_pulse_r) |-> (TXD_PIN_OUT == ir_tx_invert);
  endproperty
  a_tx_idle_lvl: assert property (p_tx_idle_lvl) else $error("tx idle level wrong");

  property p_irctl_reset;
    @(posedge CLK) !RST_N |=> (irctl_r == `SPIR_IRC_RST);
  endproperty
  a_irctl_reset: assert property (p_irctl_reset) else $error("ir control reset value");

  property p_pullup;
    @(posedge CLK) disable iff (!RST_N) PULLUP_ON;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup dropped");

  property p_pulse_ticks;
    @(posedge CLK) disable iff (!RST_N)
      tx_pulse_r |-> (pulse_ticks_r <= {1'b0, pw_eff});
  endproperty
  a_pulse_ticks: assert property (p_pulse_ticks) else $error("tx pulse wider than its code");

  property p_tx_start;
    @(posedge CLK) disable iff (!RST_N)
      (tx_zero && !tx_prev_r) |=> (!ir_enable || TXD_PIN_OUT != ir_tx_invert);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no pulse at start of zero");

  property p_vote_floor;
    @(posedge CLK) disable iff (!RST_N)
      (rx_allowed && !rx_bit_r) |-> (vote_r >= {1'b0, ir_rx_vote_count});
  endproperty
  a_vote_floor: assert property (p_vote_floor) else $error("zero before all votes");

  property p_div_reload;
    @(posedge CLK) disable iff (!RST_N)
      div_tick |=> (div_cnt_r == $past(irdiv_r) - 8'h01);
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("divider period wrong");

  property p_ir_pins;
    @(posedge CLK) disable iff (!RST_N)
      ir_enable |-> (!TXD_PIN_OE_N && RXD_PIN_OE_N);
  endproperty
  a_ir_pins: assert property (p_ir_pins) else $error("codec does not own pins");
endmodule
`default_nettype wire

// >>> rtl/spir_cfg.svh
// register offsets, field positions, reset values and timing constants for the serial pin and infrared block
`ifndef SPIR_CFG_SVH
`define SPIR_CFG_SVH
// ==================================================
// register word indices; the byte address is four times the index
`define SPIR_IDX_DIR        4'h9
`define SPIR_IDX_PORT       4'hA
`define SPIR_IDX_PUDZ       4'hB
`define SPIR_IDX_IRDIV      4'hC
`define SPIR_IDX_IRCTL      4'hE
`define SPIR_IDX_TEST       4'hF
// ==================================================
// infrared control fields
`define SPIR_IRC_EN         0
`define SPIR_IRC_SCLK       1
`define SPIR_IRC_RX_INV     2
`define SPIR_IRC_TX_INV     3
`define SPIR_IRC_VOTE_LO    4
`define SPIR_IRC_PW_LO      6
`define SPIR_IRC_RST        8'h90
// pullup and doze fields
`define SPIR_PD_DOZE        7
`define SPIR_PD_PULL        6
// ==================================================
// port pin bits
`define SPIR_PIN_TX         1
`define SPIR_PIN_RX         0
// last sample tick phase of a baud bit, which spans 16 ticks
`define SPIR_TICKS_PER_BIT  4'hF
`endif

// >>> rtl/spir_pkg.sv
// types for the serial pin and infrared block
package spir_pkg;
  typedef logic [7:0] spir_byte_t;
  typedef logic [1:0] spir_pin2_t;
  typedef enum logic [2:0] {
    SPIR_IDLE = 3'b001,
    SPIR_TXP  = 3'b010,
    SPIR_RXP  = 3'b100
  } spir_dir_e;
endpackage

// >>> tb/spir_pin_model.sv
// pin model: outside drivers and the always-on pull-ups of the two serial pins
`timescale 1ns/1ps
`default_nettype none
module spir_pin_model (
  input  wire logic       txd_out,
  input  wire logic       txd_oe_n,
  input  wire logic       rxd_out,
  input  wire logic       rxd_oe_n,
  input  wire logic [1:0] ext_en,
  input  wire logic [1:0] ext_val,
  output logic            txd_lvl,
  output logic            rxd_lvl
);
  // ==================================================
  // wire resolution
  // a released pin goes to the pull-up level, it never keeps the last value
  assign txd_lvl = !txd_oe_n ? txd_out : (ext_en[1] ? ext_val[1] : 1'b1);
  assign rxd_lvl = !rxd_oe_n ? rxd_out : (ext_en[0] ? ext_val[0] : 1'b1);
endmodule
`default_nettype wire

// >>> tb/spir_top_tb.sv
// self-checking bench for the serial pin and infrared block
`timescale 1ns/1ps
`default_nettype none
`include "spir_cfg.svh"
module spir_top_tb;
  localparam int P = 4;
  localparam int D = 3;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic doze = 1'b0, baud_tick = 1'b0, tick_en = 1'b0, stxd = 1'b1, stx_act = 1'b0, srx_act = 1'b0;
  logic [1:0] ext_en = 2'b00, ext_val = 2'b11, tcnt = 2'b00;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SERIAL_RXD, SERIAL_ENABLE, PULLUP_ON, txd_lvl, rxd_lvl;
  logic TXD_PIN_OUT, TXD_PIN_OE_N, RXD_PIN_OUT, RXD_PIN_OE_N;
  logic [32:0] exp_q[$];
  int failures = 0, total_checks = 0;
  logic [7:0] r;
  int q;
  spir_top i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DOZE(doze),
    .BAUD_X16_TICK(baud_tick), .SERIAL_TXD(stxd), .SERIAL_RXD(SERIAL_RXD), .SERIAL_TX_ACTIVE(stx_act),
    .SERIAL_RX_ACTIVE(srx_act), .SERIAL_ENABLE(SERIAL_ENABLE), .PULLUP_ON(PULLUP_ON), .TXD_PIN_IN(txd_lvl),
    .TXD_PIN_OUT(TXD_PIN_OUT), .TXD_PIN_OE_N(TXD_PIN_OE_N), .RXD_PIN_IN(rxd_lvl), .RXD_PIN_OUT(RXD_PIN_OUT),
    .RXD_PIN_OE_N(RXD_PIN_OE_N));
  spir_pin_model i_pins (.txd_out(TXD_PIN_OUT), .txd_oe_n(TXD_PIN_OE_N), .rxd_out(RXD_PIN_OUT),
    .rxd_oe_n(RXD_PIN_OE_N), .ext_en(ext_en), .ext_val(ext_val), .txd_lvl(txd_lvl), .rxd_lvl(rxd_lvl));
  // ==================================================
  // clock and a 16x baud tick every P cycles
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 2'd1;
    baud_tick <= tick_en && tcnt == 2'd3;
  end
  // ==================================================
  // comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // request held from setup until pready is seen high at an edge
  task automatic apb_x(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    if (!wr) exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    @(posedge clk);
    while (PREADY !== 1'b1) @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb_x(1'b1, {2'b00, i, 2'b00}, d, 33'h0);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    apb_x(1'b0, {2'b00, i, 2'b00}, 8'h00, {25'h0, e});
  endtask
  // read monitor: oldest note against each completed read
  always @(posedge clk) begin
    if (psel && penable && PREADY === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("read unexpected", 33'h0, 33'h1);
      else chk("read data", exp_q.pop_front(), {PSLVERR, PRDATA});
    end
  end
  // ==================================================
  // infrared encode and decode checks
  task automatic tx_pulse(input logic [1:0] w, input logic ti);
    int n;
    wr(`SPIR_IDX_IRCTL, {w, 2'b00, ti, 2'b00, 1'b1});
    n = 0;
    // a transmitter changes its bit just before a 16x tick, so widths come out whole
    @(posedge clk iff tcnt == 2'd3);
    stxd <= 1'b0;
    repeat (16 * P) begin @(posedge clk); if (TXD_PIN_OUT === ~ti) n++; end
    stxd <= 1'b1;
    repeat (16 * P) @(posedge clk);
    chk("tx pulse", (w == 2'd3 ? 3 : w + 1) * P, n);
    chk("tx idle", {32'h0, ti}, {32'h0, TXD_PIN_OUT});
    chk("tx oe_n", 33'h0, {32'h0, TXD_PIN_OE_N});
  endtask
  // short pulses leave whole ticks uncovered so votes stay short; sc picks the tick source
  task automatic rx_vote(input logic [1:0] v, input logic ri, input logic sc, input int len, input logic z);
    logic s;
    wr(`SPIR_IDX_IRCTL, {2'b10, v, 1'b0, ri, sc, 1'b1});
    s = 1'b0;
    for (int i = 0; i < len + 10 * P; i++) begin
      ext_val[0] <= (i < len) ? ri : ~ri;
      @(posedge clk);
      if (SERIAL_RXD === 1'b0) s = 1'b1;
    end
    chk("rx zero", {32'h0, z}, {32'h0, s});
  endtask
  // ==================================================
  // watchdog and main sequence
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    void'($urandom(27914));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SPIR_IDX_PORT, 8'h03);
    rd(`SPIR_IDX_IRCTL, 8'h90);
    rd(`SPIR_IDX_DIR, 8'h00);
    apb_x(1'b1, 8'h20, 8'hFF, 33'h0);
    apb_x(1'b0, 8'h20, 8'h00, {1'b1, 32'h0});
    apb_x(1'b0, 8'h29, 8'h00, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(`SPIR_IDX_DIR, r & 8'hFC);
      rd(`SPIR_IDX_DIR, r & 8'hFC);
      wr(`SPIR_IDX_PUDZ, r);
      rd(`SPIR_IDX_PUDZ, r);
      wr(`SPIR_IDX_IRDIV, r);
      rd(`SPIR_IDX_IRDIV, r);
      wr(`SPIR_IDX_TEST, r);
      rd(`SPIR_IDX_TEST, r);
      wr(`SPIR_IDX_PORT, r);
      rd(`SPIR_IDX_PORT, {r[7:2], 2'b11});
    end
    // port pins as inputs, then as outputs of the latch
    wr(`SPIR_IDX_DIR, 8'h00);
    wr(`SPIR_IDX_PORT, 8'h01);
    ext_en <= 2'b11; ext_val <= 2'b10;
    repeat (3) @(posedge clk);
    chk("oe_n in", 33'h3, {31'h0, TXD_PIN_OE_N, RXD_PIN_OE_N});
    rd(`SPIR_IDX_PORT, 8'h02);
    ext_en <= 2'b00;
    wr(`SPIR_IDX_DIR, 8'h03);
    repeat (3) @(posedge clk);
    chk("pins out", 33'h1, {29'h0, TXD_PIN_OE_N, RXD_PIN_OE_N, TXD_PIN_OUT, RXD_PIN_OUT});
    rd(`SPIR_IDX_PORT, 8'h01);
    stx_act <= 1'b1; srx_act <= 1'b1;
    wr(`SPIR_IDX_PORT, 8'h00);
    ext_en <= 2'b01; ext_val <= 2'b00;
    repeat (4) @(posedge clk);
    chk("rx oe_n", 33'h1, {32'h0, RXD_PIN_OE_N});
    chk("rx sync", 33'h0, {32'h0, SERIAL_RXD});
    chk("tx serial", 33'h1, {32'h0, TXD_PIN_OUT});
    stx_act <= 1'b0; srx_act <= 1'b0;
    wr(`SPIR_IDX_DIR, 8'h00);
    // doze stop and pull-up
    wr(`SPIR_IDX_PUDZ, 8'h80);
    doze <= 1'b1;
    repeat (2) @(posedge clk);
    chk("doze off", 33'h0, {32'h0, SERIAL_ENABLE});
    wr(`SPIR_IDX_PUDZ, 8'h00);
    repeat (2) @(posedge clk);
    chk("doze on", 33'h1, {32'h0, SERIAL_ENABLE});
    chk("pullup", 33'h1, {32'h0, PULLUP_ON});
    doze <= 1'b0;
    // infrared transmit: every width code, both polarities
    tick_en <= 1'b1;
    stx_act <= 1'b1;
    for (int k = 0; k < 8; k++) tx_pulse(k[1:0], k[2]);
    stx_act <= 1'b0;
    srx_act <= 1'b1;
    ext_en <= 2'b01;
    // infrared receive: every vote count, both levels; four votes use the divided clock
    wr(`SPIR_IDX_IRDIV, 8'(D));
    for (int k = 0; k < 8; k++) begin
      q = (k[1:0] == 2'd3) ? D : P;
      rx_vote(k[1:0], k[2], q == D, (k[1:0] + 2) * q, 1'b1);
      if (k[1:0] != 2'd0) rx_vote(k[1:0], k[2], q == D, k[1:0] * q - 1, 1'b0);
    end
    // divided system clock as sample source with the baud tick stopped
    tick_en <= 1'b0;
    rx_vote(2'd3, 1'b0, 1'b1, 5 * D, 1'b1);
    rx_vote(2'd3, 1'b0, 1'b1, 3 * D - 1, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
